// ---- hdl/mch_pkg.sv ----
// Notes on behaviour
// - Ready off: ignore all inputs but ring
// - Ready off never blocks ring or DTR
// - Ready lost mid-call ends call; next is new
// - Ready rise under autocaller proves no handover
// - DTR on keeps the modem on line
// - DTR may rise whenever terminal is ready
// - Switched: DTR stays off until ready drops
// - Quality off flags likely error, retransmit
// - Terminal rate select on means higher rate
// - Transmit only with RTS, CTS, DSR, DTR on
package mch_pkg;
	// APB register byte addresses
	localparam logic [7:0] MCH_CTRL_ADDR   = 8'h00;
	localparam logic [7:0] MCH_STATUS_ADDR = 8'h04;
	localparam logic [7:0] MCH_EVENT_ADDR  = 8'h08;
	localparam logic [7:0] MCH_TXD_ADDR    = 8'h0c;
	// Control fields
	localparam int CTRL_DTR      = 0;
	localparam int CTRL_RTS      = 1;
	localparam int CTRL_RATE_HI  = 2;
	localparam int CTRL_SWITCHED = 3;
	localparam int CTRL_ACU      = 4;
	localparam int CTRL_HANGUP   = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
	// Status fields
	localparam int ST_DSR     = 0;
	localparam int ST_CTS     = 1;
	localparam int ST_DCD     = 2;
	localparam int ST_RI      = 3;
	localparam int ST_SQD     = 4;
	localparam int ST_RATE    = 5;
	localparam int ST_CALL    = 6;
	localparam int ST_DTR_OUT = 7;
	localparam int ST_DTR_LCK = 8;
	localparam int ST_TX_OK   = 9;
	localparam int ST_RXD     = 10;
	// Sticky event fields
	localparam int EV_LOST  = 0;
	localparam int EV_NEW   = 1;
	localparam int EV_RING  = 2;
	localparam int EV_QERR  = 3;
	localparam int EV_WIDTH = 4;
	// Incoming line indices
	localparam int IN_DSR  = 0;
	localparam int IN_CTS  = 1;
	localparam int IN_DCD  = 2;
	localparam int IN_RI   = 3;
	localparam int IN_SQD  = 4;
	localparam int IN_RATE = 5;
	localparam int IN_RXD  = 6;
	localparam int IN_NUM  = 7;
	typedef enum logic [1:0] {
		MCH_IDLE = 2'b00,
		MCH_CALL = 2'b01,
		MCH_DROP = 2'b11
	} mch_call_t;
endpackage : mch_pkg

// ---- hdl/mch_sync_if.sv ----
`timescale 1ns/1ps
// Raw pins in, synchronised levels out
interface mch_sync_if #(parameter int N = 7);
	logic [N-1:0] raw;
	logic [N-1:0] sync;
	modport src (output raw, input sync);
	modport dst (input raw, output sync);
endinterface : mch_sync_if

// ---- hdl/mch_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser bank, one stage pair per line
module mch_sync #(
	parameter int N = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Lines
	mch_sync_if.dst  lines
);
	logic [N-1:0] meta_r;
	logic [N-1:0] sync_r;

	// Elaboration check: a bank needs at least one line
	if (N < 1) begin : g_bad_n
		$error("mch_sync needs at least one line");
	end

	// Per line: first stage feeds only the second
	generate
		for (genvar i = 0; i < N; i++) begin : g_line
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
				end else begin
					meta_r[i] <= lines.raw[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	assign lines.sync = sync_r;
endmodule : mch_sync

// ---- hdl/mch_top.sv ----
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Terminal-side modem control with APB registers
module mch_top (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Lines from the data set
	input  wire logic        DSR_IN,
	input  wire logic        CTS_IN,
	input  wire logic        DCD_IN,
	input  wire logic        RI_IN,
	input  wire logic        SQD_IN,
	input  wire logic        RATE_IN,
	input  wire logic        RXD_IN,
	// Lines to the data set
	output logic             DTR_OUT,
	output logic             RTS_OUT,
	output logic             RATE_SEL_OUT,
	output logic             TXD_OUT
);
	import mch_pkg::*;

	mch_sync_if #(.N(IN_NUM)) sif ();
	logic [31:0]         ctrl_r;
	logic [EV_WIDTH-1:0] event_r;
	logic                txd_bit_r;
	mch_call_t           call_r;
	logic                dtr_lock_r;
	logic                dsr_d_r;
	logic                ri_d_r;
	logic                sqd_d_r;
	logic                dsr, cts, dcd, ri, sqd, rate_in, rxd;
	logic                cts_q, dcd_q, sqd_q, rate_q, rxd_q;
	logic                dtr_nxt;
	logic                tx_ok;
	logic                ev_lost, ev_new, ev_ring, ev_qerr;
	logic                wr_en, rd_en;
	logic                addr_ok;
	logic [31:0]         status;
	logic [31:0]         rdata_nxt;

	// Synchronise every incoming line before use
	assign sif.raw = {RXD_IN, RATE_IN, SQD_IN, RI_IN, DCD_IN, CTS_IN, DSR_IN};
	mch_sync #(.N(IN_NUM)) u_sync (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.lines (sif.dst)
	);
	assign dsr     = sif.sync[IN_DSR];
	assign cts     = sif.sync[IN_CTS];
	assign dcd     = sif.sync[IN_DCD];
	assign ri      = sif.sync[IN_RI];
	assign sqd     = sif.sync[IN_SQD];
	assign rate_in = sif.sync[IN_RATE];
	assign rxd     = sif.sync[IN_RXD];

	// Without ready, all lines but ring read as off or mark
	assign cts_q  = dsr & cts;
	assign dcd_q  = dsr & dcd;
	assign sqd_q  = dsr & sqd;
	assign rate_q = dsr & rate_in;
	// Carrier loss forces mark even if the modem forgets to clamp
	assign rxd_q  = ~(dsr & dcd) | rxd;

	// Events; ring is never gated by ready or DTR
	assign ev_ring = ri & ~ri_d_r;
	// Loss counts only while the DTR line itself is still on
	assign ev_lost = ~dsr & dsr_d_r & DTR_OUT & (call_r == MCH_CALL);
	// Under an autocaller a rising ready does not open a call
	assign ev_new  = dsr & ~dsr_d_r & ~ctrl_r[CTRL_ACU];
	// Ready loss alone must not look like a quality error
	assign ev_qerr = dsr & ~sqd & sqd_d_r;

	// Call tracking
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			call_r <= MCH_IDLE;
		end else begin
			case (call_r)
				MCH_IDLE: begin
					if (dsr & ctrl_r[CTRL_DTR] & ~ctrl_r[CTRL_ACU]) call_r <= MCH_CALL;
				end
				MCH_CALL: begin
					if (ev_lost | ctrl_r[CTRL_HANGUP]) call_r <= MCH_DROP;
					else if (~dsr) call_r <= MCH_IDLE;
				end
				MCH_DROP: begin
					if (~dsr) call_r <= MCH_IDLE; // Next ready is a new call
				end
				default: call_r <= MCH_IDLE;
			endcase
		end
	end

	// DTR reassertion lock in switched service until ready drops
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			dtr_lock_r <= 1'b0;
		end else if (DTR_OUT & ~dtr_nxt & ctrl_r[CTRL_SWITCHED] & dsr) begin
			dtr_lock_r <= 1'b1;
		end else if (~dsr | ~ctrl_r[CTRL_SWITCHED]) begin
			dtr_lock_r <= 1'b0;
		end
	end

	// Software DTR; lost call and hangup force it off
	assign dtr_nxt = ctrl_r[CTRL_DTR] & ~dtr_lock_r & ~ctrl_r[CTRL_HANGUP]
		& (call_r != MCH_DROP);

	// Transmit gate needs all four lines on
	assign tx_ok = ctrl_r[CTRL_RTS] & cts_q & dsr & DTR_OUT;

	// Line outputs, all registered
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			DTR_OUT      <= 1'b0;
			RTS_OUT      <= 1'b0;
			RATE_SEL_OUT <= 1'b0;
			TXD_OUT      <= 1'b1;
		end else begin
			DTR_OUT      <= dtr_nxt;
			RTS_OUT      <= ctrl_r[CTRL_RTS];
			RATE_SEL_OUT <= ctrl_r[CTRL_RATE_HI];
			TXD_OUT      <= tx_ok ? txd_bit_r : 1'b1;
		end
	end

	// Edge history for event detection
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			dsr_d_r <= 1'b0;
			ri_d_r  <= 1'b0;
			sqd_d_r <= 1'b0;
		end else begin
			dsr_d_r <= dsr;
			ri_d_r  <= ri;
			sqd_d_r <= sqd_q;
		end
	end

	// APB decode; zero wait states
	assign wr_en   = PSEL & PENABLE & PWRITE;
	assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
	assign addr_ok = (PADDR == MCH_CTRL_ADDR) | (PADDR == MCH_STATUS_ADDR)
		| (PADDR == MCH_EVENT_ADDR) | (PADDR == MCH_TXD_ADDR);

	// Control and transmit bit registers; hangup self-clears
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ctrl_r    <= CTRL_RESET;
			txd_bit_r <= 1'b1;
		end else begin
			if (wr_en & (PADDR == MCH_CTRL_ADDR)) begin
				ctrl_r <= 32'(PWDATA[CTRL_HANGUP:0]); // Upper bits read as zero
			end else begin
				ctrl_r[CTRL_HANGUP] <= 1'b0;
			end
			if (wr_en & (PADDR == MCH_TXD_ADDR)) txd_bit_r <= PWDATA[0];
		end
	end

	// Sticky events, write one to clear; a new event wins
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			event_r <= '0;
		end else begin
			event_r <= (event_r & ~((wr_en & (PADDR == MCH_EVENT_ADDR)) ? PWDATA[EV_WIDTH-1:0] : '0))
				| {ev_qerr, ev_ring, ev_new, ev_lost};
		end
	end

	// Status word; ring reported regardless of ready
	always_comb begin
		status             = 32'h0;
		status[ST_DSR]     = dsr;
		status[ST_CTS]     = cts_q;
		status[ST_DCD]     = dcd_q;
		status[ST_RI]      = ri;
		status[ST_SQD]     = sqd_q;
		status[ST_RATE]    = rate_q;
		status[ST_CALL]    = (call_r == MCH_CALL);
		status[ST_DTR_OUT] = DTR_OUT;
		status[ST_DTR_LCK] = dtr_lock_r;
		status[ST_TX_OK]   = tx_ok;
		status[ST_RXD]     = rxd_q;
	end

	// Read mux
	always_comb begin
		rdata_nxt = 32'h0;
		case (PADDR)
			MCH_CTRL_ADDR:   rdata_nxt = ctrl_r;
			MCH_STATUS_ADDR: rdata_nxt = status;
			MCH_EVENT_ADDR:  rdata_nxt = {{(32-EV_WIDTH){1'b0}}, event_r};
			MCH_TXD_ADDR:    rdata_nxt = {31'h0, txd_bit_r};
			default:         rdata_nxt = 32'h0;
		endcase
	end

	// Read data captured in setup, ready and error in access
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			PRDATA  <= 32'h0;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			if (rd_en) PRDATA <= rdata_nxt;
			PREADY  <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
		end
	end
endmodule : mch_top

// ---- verif/mch_top_checker.sv ----
`timescale 1ns/1ps
// Port-level temporal checks on the modem control block
module mch_top_checker (
	// Clock, reset and bus handshake
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Modem lines
	input wire logic DSR_IN,
	input wire logic DTR_OUT,
	input wire logic RTS_OUT,
	input wire logic RATE_SEL_OUT,
	input wire logic TXD_OUT
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Zero-wait slave: answer one cycle after setup
	a_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no PREADY after setup");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("PREADY longer than one cycle");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("PSLVERR without PREADY");
	// Transmit line held at mark without ready or request
	a_txd_nodsr: assert property (!DSR_IN [*4] |-> TXD_OUT)
		else $error("data sent while data set not ready");
	a_txd_norts: assert property (!RTS_OUT [*2] |-> TXD_OUT)
		else $error("data sent without request");
	// Lost ready mid-call drops DTR after the synchroniser
	a_call_lost: assert property ($fell(DSR_IN) && DTR_OUT |-> ##[2:4] !DTR_OUT)
		else $error("call not ended on lost ready");
	a_sync_delay: assert property ($fell(DSR_IN) |=> $stable(DTR_OUT))
		else $error("line acted on before synchroniser");
	// Selector outputs move only after a register write
	a_rate_write: assert property ($changed(RATE_SEL_OUT) |->
		$past(PSEL && PENABLE && PWRITE) || $past(PSEL && PENABLE && PWRITE, 2))
		else $error("rate select changed without write");
	a_rts_write: assert property ($changed(RTS_OUT) |->
		$past(PSEL && PENABLE && PWRITE) || $past(PSEL && PENABLE && PWRITE, 2))
		else $error("request changed without write");
endmodule : mch_top_checker
bind mch_top mch_top_checker u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .DSR_IN(DSR_IN),
	.DTR_OUT(DTR_OUT), .RTS_OUT(RTS_OUT), .RATE_SEL_OUT(RATE_SEL_OUT), .TXD_OUT(TXD_OUT));

// ---- verif/mch_dce_model.sv ----
`timescale 1ns/1ps
// Behavioural data set on the far side of the pins
module mch_dce_model (
	// Clock and bench commands
	input  wire logic clk,
	input  wire logic ring,
	input  wire logic drop,
	input  wire logic carrier,
	input  wire logic q_bad,
	input  wire logic rate_hi,
	input  wire logic rx_bit,
	// Terminal lines
	input  wire logic dtr,
	input  wire logic rts,
	output logic      dsr,
	output logic      cts,
	output logic      dcd,
	output logic      ri,
	output logic      sqd,
	output logic      rate,
	output logic      rxd
);
	logic       on_r = 1'b0;
	logic [4:0] hold_r = '0;
	logic [2:0] cond_r = '0;
	logic [2:0] rq_r = '0;
	logic [2:0] cg_r = '0;
	// Answer on ring with DTR; linger to finish sending
	always @(posedge clk) begin
		hold_r <= dtr ? '0 : hold_r + 5'h01;
		if (drop) on_r <= 1'b0;
		else if (ring && dtr) on_r <= 1'b1;
		else if (!dtr && &hold_r) on_r <= 1'b0;
		cond_r <= {cond_r[1:0], dsr & rts};
		rq_r <= {rq_r[1:0], rts};
		cg_r <= {cg_r[1:0], carrier}; // Guard delay on carrier gain and loss
	end
	assign dsr = on_r;
	assign cts = &cond_r & dsr & rts;
	assign dcd = cg_r[2] & dsr & !rts & !(|rq_r);
	assign ri = ring;
	assign sqd = !q_bad;
	assign rate = rate_hi;
	assign rxd = dcd ? rx_bit : 1'b1;
endmodule : mch_dce_model

// ---- verif/mch_top_test.sv ----
`timescale 1ns/1ps
// Register-level tests of terminal modem control
module mch_top_test;
	import mch_pkg::*;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwd = '0, prd, rd;
	logic        pready, perr, err, dsr, cts, dcd, ri, sqd, rate, rxd, dtr, rts, rsel, txd;
	logic        ring = 0, drop = 0, car = 0, qb = 0, rhi = 1, rxb = 0;
	int          bad_count = 0, n_compared = 0;
	always #2.5 clk = ~clk;
	mch_top u_mch_top (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .DSR_IN(dsr),
		.CTS_IN(cts), .DCD_IN(dcd), .RI_IN(ri), .SQD_IN(sqd), .RATE_IN(rate), .RXD_IN(rxd),
		.DTR_OUT(dtr), .RTS_OUT(rts), .RATE_SEL_OUT(rsel), .TXD_OUT(txd));
	mch_dce_model u_mch_dce_model (.clk(clk), .ring(ring), .drop(drop), .carrier(car), .q_bad(qb),
		.rate_hi(rhi), .rx_bit(rxb), .dtr(dtr), .rts(rts), .dsr(dsr), .cts(cts), .dcd(dcd), .ri(ri),
		.sqd(sqd), .rate(rate), .rxd(rxd));
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// One bus transfer; held until PREADY is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prd;
		err = perr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask : apb
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(0, a, 0);
		chk(n, e & m, rd & m);
	endtask : rc
	function automatic logic [31:0] f(input int i);
		return 32'h1 << i;
	endfunction : f
	// Main sequence
	initial begin
		cyc(20);
		rst_n <= 1;
		cyc(1);
		rc("ctrl", MCH_CTRL_ADDR, '1, CTRL_RESET);
		rc("status", MCH_STATUS_ADDR, '1, f(ST_RXD));
		rc("txd", MCH_TXD_ADDR, '1, 1);
		rc("unmapped", 8'h10, '1, 0);
		chk("slverr", 1, err);
		$display("reset test done");
		ring <= 1;
		cyc(5);
		rc("ri", MCH_STATUS_ADDR, f(ST_RI) | f(ST_DSR), f(ST_RI));
		rc("ring ev", MCH_EVENT_ADDR, f(EV_RING), f(EV_RING));
		ring <= 0;
		apb(1, MCH_EVENT_ADDR, '1);
		rc("ev clear", MCH_EVENT_ADDR, '1, 0);
		apb(1, MCH_CTRL_ADDR, 32'h9);
		cyc(2);
		chk("dtr", 1, dtr);
		$display("ring test done");
		ring <= 1;
		cyc(8);
		rc("answer", MCH_STATUS_ADDR, f(ST_DSR) | f(ST_SQD) | f(ST_CALL) | f(ST_RATE), '1);
		rc("new ev", MCH_EVENT_ADDR, f(EV_NEW), f(EV_NEW));
		ring <= 0;
		$display("answer test done");
		car <= 1;
		qb <= 1;
		cyc(8);
		rc("carrier", MCH_STATUS_ADDR, f(ST_DCD) | f(ST_RXD) | f(ST_SQD), f(ST_DCD));
		rc("quality", MCH_EVENT_ADDR, f(EV_QERR), f(EV_QERR));
		car <= 0;
		qb <= 0;
		$display("line test done");
		apb(1, MCH_TXD_ADDR, 0);
		cyc(2);
		chk("txd idle", 1, txd);
		apb(1, MCH_CTRL_ADDR, 32'hf);
		cyc(12);
		chk("rate hi", 1, rsel);
		chk("txd send", 0, txd);
		chk("rts on", 1, rts);
		apb(1, MCH_CTRL_ADDR, 32'h9);
		cyc(2);
		chk("rate lo", 0, rsel);
		chk("txd stop", 1, txd);
		chk("rts off", 0, rts);
		$display("transmit test done");
		apb(1, MCH_EVENT_ADDR, '1);
		drop <= 1;
		cyc(8);
		drop <= 0;
		rc("lost", MCH_EVENT_ADDR, f(EV_LOST) | f(EV_NEW), f(EV_LOST));
		ring <= 1;
		cyc(8);
		ring <= 0;
		rc("recall", MCH_EVENT_ADDR, f(EV_NEW), f(EV_NEW));
		$display("lost call test done");
		apb(1, MCH_CTRL_ADDR, 32'h29);
		rc("hangup", MCH_STATUS_ADDR, f(ST_CALL) | f(ST_DTR_OUT), 0);
		cyc(40);
		ring <= 1;
		cyc(8);
		ring <= 0;
		$display("hangup test done");
		apb(1, MCH_CTRL_ADDR, 32'h8);
		rc("lock", MCH_STATUS_ADDR, f(ST_DTR_LCK) | f(ST_DSR), '1);
		apb(1, MCH_CTRL_ADDR, 32'h9);
		cyc(2);
		chk("dtr held", 0, dtr);
		cyc(40);
		rc("unlock", MCH_STATUS_ADDR, f(ST_DTR_LCK) | f(ST_DTR_OUT), f(ST_DTR_OUT));
		$display("lock test done");
		apb(1, MCH_EVENT_ADDR, '1);
		apb(1, MCH_CTRL_ADDR, 32'h19);
		ring <= 1;
		cyc(8);
		ring <= 0;
		rc("acu", MCH_STATUS_ADDR, f(ST_DSR) | f(ST_CALL), f(ST_DSR));
		rc("acu ev", MCH_EVENT_ADDR, f(EV_NEW), 0);
		apb(1, MCH_CTRL_ADDR, 32'h18);
		cyc(40);
		$display("autocaller test done");
		results();
	end
	// Cut a hang short well past the expected run
	initial begin
		cyc(5000);
		bad_count++;
		results();
	end
endmodule : mch_top_test
